// ===== rtl/rcsb_cfg.svh
// What this block does
// - 8-bit count, prescale 1000, 100 us tick
// - Count readable only in DSI3 or PSI5 diagnostic
// - Status readable only in DSI3 or PSI5 diagnostic
// - Signal-processing summary ORs five flags
// - Link summary follows oscillator training fault
// - Memory/heat summary ORs five memory/temperature bits
// - Power summary ORs seven power fault bits
// - Shared recovery timer reloads, then counts down
// - DSI3 strict: silent, then one error response
// - DSI3 strict: read/report clears at zero
// - Holdoff or PSI5: suppress, auto-clear at zero
// - Reset-occurred set at reset, read/report clears
// - Initialising after reset or config nibble change
// - Fault-free power status clears after two reads
// - Buffer low monitor sets bit, reloads timer
// - Bus input low monitor sets bit, reloads timer
// - Memory/heat faults clear on read or report
// - Write-active follows the memory write itself
`ifndef RCSB_CFG_SVH
`define RCSB_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define RCSB_ADDR_COUNT     8'h00
`define RCSB_ADDR_SUMMARY   8'h01
`define RCSB_ADDR_POWER     8'h02

// ****************************************
// Protocol select codes
// ****************************************
`define RCSB_PSEL_DSI3_A    3'h0
`define RCSB_PSEL_DSI3_B    3'h3
`define RCSB_PSEL_PSI5_A    3'h1
`define RCSB_PSEL_PSI5_B    3'h5

// ****************************************
// Timing: primary oscillator made from the system clock
// ****************************************
`define RCSB_CLK_MHZ        6'h19
`define RCSB_OSC_MHZ        6'h0A
`define RCSB_PRESCALE_LAST  10'h3E7

// ****************************************
// Field layout and reset values
// ****************************************
`define RCSB_PWR_MASK       8'hEF
`define RCSB_COUNT_RST      8'h00
`define RCSB_ZERO8          8'h00
`define RCSB_TIMER_W        24

`endif

// ===== rtl/rcsb_pkg.sv
package rcsb_pkg;
    typedef enum logic [1:0] {
        RCSB_PROTO_DSI3,
        RCSB_PROTO_PSI5,
        RCSB_PROTO_OTHER
    } rcsb_proto_t;

    typedef enum logic [1:0] {
        RCSB_PWR_CLEAN,
        RCSB_PWR_RECOVER,
        RCSB_PWR_REPORT
    } rcsb_pwr_state_t;
endpackage

// ===== rtl/rcsb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rcsb_if;
    import rcsb_pkg::*;
    logic [7:0]  count;
    rcsb_proto_t proto;
    logic        holdoff_dis;
    logic [7:0]  pwr_mon;
    logic        pwr_read;
    logic        tx_done;
    logic [7:0]  pwr_bits;
    logic        tx_hold;
    logic        tx_err_code;

    modport tick (output count);
    modport pwr  (input proto, holdoff_dis, pwr_mon, pwr_read, tx_done,
                  output pwr_bits, tx_hold, tx_err_code);
    modport top  (input count, pwr_bits, tx_hold, tx_err_code,
                  output proto, holdoff_dis, pwr_mon, pwr_read, tx_done);
endinterface
`default_nettype wire

// ===== rtl/rcsb_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcsb_cfg.svh"
module rcsb_tick (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    rcsb_if.tick     tk
);
    import rcsb_pkg::*;

    // ****************************************
    // Oscillator strobe, prescaler and rolling counter
    // ****************************************
    // Phase accumulator makes the oscillator rate; prescaler stays /1000
    logic [4:0] phase;
    logic [4:0] next_phase;
    logic [9:0] pre;
    logic [9:0] next_pre;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [5:0] sum;

    always_comb begin
        sum        = {1'b0, phase} + `RCSB_OSC_MHZ;
        next_phase = sum[4:0];
        next_pre   = pre;
        next_cnt   = cnt;
        if (sum >= `RCSB_CLK_MHZ) begin
            next_phase = 5'(sum - `RCSB_CLK_MHZ);
            if (pre == `RCSB_PRESCALE_LAST) begin
                next_pre = '0;
                next_cnt = cnt + 1'b1;
            end else begin
                next_pre = pre + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase <= '0;
            pre   <= '0;
            cnt   <= `RCSB_COUNT_RST;
        end else begin
            phase <= next_phase;
            pre   <= next_pre;
            cnt   <= next_cnt;
        end
    end

    assign tk.count = cnt;
endmodule
`default_nettype wire

// ===== rtl/rcsb_power.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcsb_cfg.svh"
module rcsb_power #(
    parameter int RECOVERY_CYCLES = 10000
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    rcsb_if.pwr      pw
);
    import rcsb_pkg::*;

    localparam logic [`RCSB_TIMER_W-1:0] RELOAD =
        `RCSB_TIMER_W'(RECOVERY_CYCLES);

    // ****************************************
    // Monitor synchronisers
    // ****************************************
    logic [7:0] mon_meta;
    logic [7:0] mon_sync;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mon_meta <= `RCSB_ZERO8;
            mon_sync <= `RCSB_ZERO8;
        end else begin
            mon_meta <= pw.pwr_mon;
            mon_sync <= mon_meta;
        end
    end

    // ****************************************
    // Recovery timer and fault bits
    // ****************************************
    logic [`RCSB_TIMER_W-1:0] timer;
    logic [`RCSB_TIMER_W-1:0] next_timer;
    logic [7:0]               bits;
    logic [7:0]               next_bits;
    logic                     rd_once;
    logic                     next_rd_once;
    logic                     hold;
    logic                     next_hold;
    rcsb_pwr_state_t          state;
    rcsb_pwr_state_t          next_state;
    logic [7:0]               raw;
    logic                     any_raw;
    logic                     strict;
    logic                     clear;

    always_comb begin
        raw          = mon_sync & `RCSB_PWR_MASK;
        any_raw      = |raw;
        strict       = (pw.proto == RCSB_PROTO_DSI3) && !pw.holdoff_dis;
        next_timer   = timer;
        if (any_raw) begin
            next_timer = RELOAD;
        end else if (timer != '0) begin
            next_timer = timer - 1'b1;
        end
        clear        = 1'b0;
        if (timer == '0) begin
            if (strict) begin
                clear = pw.pwr_read || pw.tx_done;
            end else begin
                clear = 1'b1;
            end
        end
        next_rd_once = rd_once;
        if (any_raw || bits == `RCSB_ZERO8) begin
            next_rd_once = 1'b0;
        end else if (pw.pwr_read) begin
            next_rd_once = !rd_once;
            if (rd_once) begin
                clear = 1'b1;
            end
        end
        // A fresh fault wins over a clear
        next_bits    = (clear ? `RCSB_ZERO8 : bits) | raw;
        next_hold    = next_timer != '0;
        next_state   = state;
        unique case (state)
            RCSB_PWR_CLEAN: begin
                if (any_raw) begin
                    next_state = RCSB_PWR_RECOVER;
                end
            end
            RCSB_PWR_RECOVER: begin
                if (!any_raw && timer == 24'h00_0001) begin
                    next_state = strict ? RCSB_PWR_REPORT
                                        : RCSB_PWR_CLEAN;
                end
            end
            RCSB_PWR_REPORT: begin
                if (any_raw) begin
                    next_state = RCSB_PWR_RECOVER;
                end else if (pw.tx_done) begin
                    next_state = RCSB_PWR_CLEAN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer   <= '0;
            bits    <= `RCSB_ZERO8;
            rd_once <= 1'b0;
            hold    <= 1'b0;
            state   <= RCSB_PWR_CLEAN;
        end else begin
            timer   <= next_timer;
            bits    <= next_bits;
            rd_once <= next_rd_once;
            hold    <= next_hold;
            state   <= next_state;
        end
    end

    assign pw.pwr_bits    = bits;
    assign pw.tx_hold     = hold;
    assign pw.tx_err_code = state == RCSB_PWR_REPORT;
endmodule
`default_nettype wire

// ===== rtl/rcsb_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcsb_cfg.svh"
module rcsb_bank #(
    parameter int RECOVERY_CYCLES = 10000,
    parameter int STARTUP_CYCLES  = 10000
) (
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic [2:0] protocol_select_i,
    input  wire logic       psi5_diag_mode_i,
    input  wire logic       power_fault_holdoff_disable_i,
    input  wire logic       reg_rd_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] channel_user_config_i,
    input  wire logic [7:0] power_monitor_i,
    input  wire logic [4:0] dsp_status_i,
    input  wire logic       oscillator_training_fault_i,
    input  wire logic [3:0] memory_fault_event_i,
    input  wire logic       memory_write_active_i,
    input  wire logic       memory_status_read_i,
    input  wire logic       factory_test_active_i,
    input  wire logic       tx_done_i,
    output var  logic [7:0] rd_data_o,
    output var  logic       rd_valid_o,
    output var  logic       acc_refused_o,
    output var  logic       tx_hold_o,
    output var  logic       tx_error_code_o
);
    import rcsb_pkg::*;

    localparam logic [`RCSB_TIMER_W-1:0] STARTUP =
        `RCSB_TIMER_W'(STARTUP_CYCLES);

    rcsb_if link ();

    // ****************************************
    // Submodules
    // ****************************************
    rcsb_tick u_tick (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .tk        (link.tick)
    );

    rcsb_power #(
        .RECOVERY_CYCLES (RECOVERY_CYCLES)
    ) u_power (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pw        (link.pwr)
    );

    // ****************************************
    // Mode decode and access check
    // ****************************************
    rcsb_proto_t proto;
    logic        readable;
    logic        addr_hit;
    logic        rd_ok;

    always_comb begin
        unique case (protocol_select_i)
            `RCSB_PSEL_DSI3_A, `RCSB_PSEL_DSI3_B: proto = RCSB_PROTO_DSI3;
            `RCSB_PSEL_PSI5_A, `RCSB_PSEL_PSI5_B: proto = RCSB_PROTO_PSI5;
            default:                              proto = RCSB_PROTO_OTHER;
        endcase
        readable = (proto == RCSB_PROTO_DSI3) ||
                   (proto == RCSB_PROTO_PSI5 && psi5_diag_mode_i);
        addr_hit = (reg_addr_i == `RCSB_ADDR_COUNT)   ||
                   (reg_addr_i == `RCSB_ADDR_SUMMARY) ||
                   (reg_addr_i == `RCSB_ADDR_POWER);
        // Only a served read has side effects
        rd_ok    = reg_rd_i && !reg_wr_i && readable && addr_hit;
    end

    assign link.proto       = proto;
    assign link.holdoff_dis = power_fault_holdoff_disable_i;
    assign link.pwr_mon     = power_monitor_i;
    assign link.pwr_read    = rd_ok && reg_addr_i == `RCSB_ADDR_POWER;
    assign link.tx_done     = tx_done_i;

    // ****************************************
    // Sticky status bits
    // ****************************************
    logic                     reset_occurred;
    logic                     next_reset_occurred;
    logic                     initialising;
    logic                     next_initialising;
    logic [`RCSB_TIMER_W-1:0] init_timer;
    logic [`RCSB_TIMER_W-1:0] next_init_timer;
    logic [3:0]               cfg_nibble;
    logic [3:0]               next_cfg_nibble;
    logic [3:0]               mem_faults;
    logic [3:0]               next_mem_faults;
    logic                     sum_read;

    always_comb begin
        sum_read            = rd_ok && reg_addr_i == `RCSB_ADDR_SUMMARY;
        next_reset_occurred = reset_occurred;
        if (sum_read || tx_done_i) begin
            next_reset_occurred = 1'b0;
        end
        next_cfg_nibble     = channel_user_config_i[7:4];
        next_init_timer     = init_timer;
        next_initialising   = initialising;
        if (channel_user_config_i[7:4] != cfg_nibble) begin
            next_init_timer   = STARTUP;
            next_initialising = 1'b1;
        end else if (init_timer != '0) begin
            next_init_timer   = init_timer - 1'b1;
        end else begin
            next_initialising = 1'b0;
        end
        next_mem_faults     = mem_faults;
        if (memory_status_read_i || tx_done_i) begin
            next_mem_faults = '0;
        end
        // A new event wins over a clear
        next_mem_faults     = next_mem_faults | memory_fault_event_i;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reset_occurred <= 1'b1;
            initialising   <= 1'b1;
            init_timer     <= STARTUP;
            cfg_nibble     <= '0;
            mem_faults     <= '0;
        end else begin
            reset_occurred <= next_reset_occurred;
            initialising   <= next_initialising;
            init_timer     <= next_init_timer;
            cfg_nibble     <= next_cfg_nibble;
            mem_faults     <= next_mem_faults;
        end
    end

    // ****************************************
    // Summary bits
    // ****************************************
    logic [7:0] summary_status;
    logic       dsp_fault_summary;
    logic       link_fault_summary;
    logic       memory_heat_fault_summary;
    logic       power_fault_summary;

    always_comb begin
        dsp_fault_summary         = |dsp_status_i;
        link_fault_summary        = oscillator_training_fault_i;
        memory_heat_fault_summary = (|mem_faults) ||
                                    memory_write_active_i;
        power_fault_summary       = |link.pwr_bits;
        summary_status            = {dsp_fault_summary,
                                     1'b0,
                                     link_fault_summary,
                                     memory_heat_fault_summary,
                                     power_fault_summary,
                                     factory_test_active_i,
                                     reset_occurred,
                                     initialising};
    end

    // ****************************************
    // Read answer
    // ****************************************
    // Writes only show up as refused
    logic [7:0] rd_data;
    logic [7:0] next_rd_data;
    logic       rd_valid;
    logic       next_rd_valid;
    logic       refused;
    logic       next_refused;

    always_comb begin
        next_rd_data  = `RCSB_ZERO8;
        if (rd_ok) begin
            unique case (reg_addr_i)
                `RCSB_ADDR_COUNT:   next_rd_data = link.count;
                `RCSB_ADDR_SUMMARY: next_rd_data = summary_status;
                `RCSB_ADDR_POWER:   next_rd_data = link.pwr_bits;
                default:            next_rd_data = `RCSB_ZERO8;
            endcase
        end
        next_rd_valid = reg_rd_i && !reg_wr_i;
        next_refused  = reg_wr_i || (reg_rd_i && !rd_ok);
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data  <= `RCSB_ZERO8;
            rd_valid <= 1'b0;
            refused  <= 1'b0;
        end else begin
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
            refused  <= next_refused;
        end
    end

    assign rd_data_o       = rd_data;
    assign rd_valid_o      = rd_valid;
    assign acc_refused_o   = refused;
    assign tx_hold_o       = link.tx_hold;
    assign tx_error_code_o = link.tx_err_code;
endmodule
`default_nettype wire

// ===== bench/rcsb_bank_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcsb_cfg.svh"
module rcsb_bank_props #(
    parameter int RECOVERY_CYCLES = 10000
) (
    input wire logic       clk_sys_i,
    input wire logic       resetn_i,
    input wire logic [2:0] protocol_select_i,
    input wire logic       psi5_diag_mode_i,
    input wire logic       power_fault_holdoff_disable_i,
    input wire logic       reg_rd_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] power_monitor_i,
    input wire logic [4:0] dsp_status_i,
    input wire logic       oscillator_training_fault_i,
    input wire logic       factory_test_active_i,
    input wire logic       tx_done_i,
    input wire logic [7:0] rd_data_o,
    input wire logic       rd_valid_o,
    input wire logic       acc_refused_o,
    input wire logic       tx_hold_o,
    input wire logic       tx_error_code_o
);
    // ****************************************
    // Helpers
    // ****************************************
    int   quiet_cnt;
    int   next_quiet;
    logic rdbl;
    logic rd_go;
    assign rdbl = protocol_select_i inside {`RCSB_PSEL_DSI3_A,
                  `RCSB_PSEL_DSI3_B} || (psi5_diag_mode_i &&
                  protocol_select_i inside {`RCSB_PSEL_PSI5_A,
                  `RCSB_PSEL_PSI5_B});
    assign rd_go = reg_rd_i && !reg_wr_i && rdbl;
    // Saturates: a long quiet run cannot wrap
    always_comb begin
        next_quiet = quiet_cnt;
        if (power_monitor_i != 8'h00) begin
            next_quiet = 0;
        end else if (quiet_cnt < 1000000) begin
            next_quiet = quiet_cnt + 1;
        end
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            quiet_cnt <= 0;
        end else begin
            quiet_cnt <= next_quiet;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // ****************************************
    // Properties
    // ****************************************
    property p_rd_ok;
        rd_go && reg_addr_i <= `RCSB_ADDR_POWER
            |=> rd_valid_o && !acc_refused_o;
    endproperty
    a_rd_ok: assert property (p_rd_ok)
        else $error("read not served");
    property p_rd_mode;
        reg_rd_i && !reg_wr_i && !rdbl |=> acc_refused_o && rd_valid_o
            && rd_data_o == 8'h00;
    endproperty
    a_rd_mode: assert property (p_rd_mode)
        else $error("mode read served");
    property p_wr_ign;
        reg_wr_i |=> acc_refused_o && !rd_valid_o;
    endproperty
    a_wr_ign: assert property (p_wr_ign)
        else $error("write served");
    property p_unmapped;
        rd_go && reg_addr_i > `RCSB_ADDR_POWER
            |=> acc_refused_o && rd_data_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped served");
    property p_valid_cause;
        rd_valid_o |-> $past(reg_rd_i && !reg_wr_i);
    endproperty
    a_valid_cause: assert property (p_valid_cause)
        else $error("stray valid");
    property p_hold_rise;
        power_monitor_i != 8'h00 |-> ##[1:4] tx_hold_o;
    endproperty
    a_hold_rise: assert property (p_hold_rise)
        else $error("no hold");
    property p_hold_len;
        $fell(tx_hold_o) |-> quiet_cnt >= RECOVERY_CYCLES
            && quiet_cnt <= RECOVERY_CYCLES + 4;
    endproperty
    a_hold_len: assert property (p_hold_len)
        else $error("hold length");
    property p_err_rise;
        $rose(tx_error_code_o) |-> !tx_hold_o
            && ($past(tx_hold_o) || $past(tx_hold_o, 2))
            && !power_fault_holdoff_disable_i
            && protocol_select_i inside {`RCSB_PSEL_DSI3_A,
                                         `RCSB_PSEL_DSI3_B};
    endproperty
    a_err_rise: assert property (p_err_rise)
        else $error("stray error code");
    property p_err_once;
        tx_error_code_o && tx_done_i |=> !tx_error_code_o;
    endproperty
    a_err_once: assert property (p_err_once)
        else $error("error code kept");
    property p_summary;
        rd_go && reg_addr_i == `RCSB_ADDR_SUMMARY && $stable(dsp_status_i)
            && $stable(oscillator_training_fault_i)
            && $stable(factory_test_active_i)
            |=> rd_data_o[7] == ($past(dsp_status_i) != 5'h00)
            && rd_data_o[5] == $past(oscillator_training_fault_i)
            && rd_data_o[2] == $past(factory_test_active_i)
            && !rd_data_o[6];
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary bits");
    property p_pwr_rsvd;
        rd_go && reg_addr_i == `RCSB_ADDR_POWER |=> !rd_data_o[4];
    endproperty
    a_pwr_rsvd: assert property (p_pwr_rsvd)
        else $error("reserved bit");
endmodule
bind rcsb_bank rcsb_bank_props #(.RECOVERY_CYCLES(RECOVERY_CYCLES))
    props_u (.*);
`default_nettype wire

// ===== bench/rcsb_master.sv
`timescale 1ns/1ps
`default_nettype none
module rcsb_master (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rd_data_i,
    input  wire logic       acc_refused_i,
    output var  logic       reg_rd_o,
    output var  logic       reg_wr_o,
    output var  logic [7:0] reg_addr_o
);
    // ****************************************
    // One-cycle request, answer one cycle later
    // ****************************************
    initial begin
        reg_rd_o   = 1'b0;
        reg_wr_o   = 1'b0;
        reg_addr_o = 8'h00;
    end
    task automatic access(input logic wr, input logic [7:0] addr,
                          output logic [7:0] data, output logic refused);
        @(posedge clk_sys_i);
        reg_rd_o   <= !wr;
        reg_wr_o   <= wr;
        reg_addr_o <= addr;
        @(posedge clk_sys_i);
        reg_rd_o   <= 1'b0;
        reg_wr_o   <= 1'b0;
        // Idle address scrambled against stale use
        reg_addr_o <= ~addr;
        #1;
        data    = rd_data_i;
        refused = acc_refused_i;
    endtask
endmodule
`default_nettype wire

// ===== bench/rcsb_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcsb_cfg.svh"
module rcsb_bank_test;
    localparam int REC   = 20;
    localparam int START = 20;
    logic       clk_sys_i = 1'b0;
    logic       resetn_i  = 1'b0;
    logic [2:0] psel      = 3'h0;
    logic       diag      = 1'b0;
    logic       hold_dis  = 1'b0;
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] cfg       = 8'h00;
    logic [7:0] pmon      = 8'h00;
    logic [4:0] dsp       = 5'h00;
    logic       osc       = 1'b0;
    logic [3:0] mev       = 4'h0;
    logic       mwa       = 1'b0;
    logic       mrd       = 1'b0;
    logic       ftest     = 1'b0;
    logic       txd       = 1'b0;
    logic [7:0] rdata;
    logic       rvalid;
    logic       refused;
    logic       hold;
    logic       errc;
    logic [7:0] d;
    logic [7:0] c1;
    logic       rf;
    int         miscompares = 0;
    int         compares    = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    rcsb_bank #(.RECOVERY_CYCLES(REC), .STARTUP_CYCLES(START)) dut_u (
        .clk_sys_i, .resetn_i,
        .protocol_select_i(psel), .psi5_diag_mode_i(diag),
        .power_fault_holdoff_disable_i(hold_dis), .reg_rd_i(rd),
        .reg_wr_i(wr), .reg_addr_i(addr), .channel_user_config_i(cfg),
        .power_monitor_i(pmon), .dsp_status_i(dsp),
        .oscillator_training_fault_i(osc), .memory_fault_event_i(mev),
        .memory_write_active_i(mwa), .memory_status_read_i(mrd),
        .factory_test_active_i(ftest), .tx_done_i(txd),
        .rd_data_o(rdata), .rd_valid_o(rvalid), .acc_refused_o(refused),
        .tx_hold_o(hold), .tx_error_code_o(errc));
    rcsb_master master_u (
        .clk_sys_i(clk_sys_i), .rd_data_i(rdata), .acc_refused_i(refused),
        .reg_rd_o(rd), .reg_wr_o(wr), .reg_addr_o(addr));
    // ****************************************
    // Tasks
    // ****************************************
    task stop_test;
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask
    task rdchk(input logic [7:0] a, input logic [7:0] exp);
        master_u.access(1'b0, a, d, rf);
        chk("read data", exp, d);
        chk("read refused", 8'h00, {7'h00, rf});
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task tx_pulse;
        @(posedge clk_sys_i);
        txd <= 1'b1;
        @(posedge clk_sys_i);
        txd <= 1'b0;
        #1;
    endtask
    // how: 0 read clears, 1 report clears, 2 auto, 3 double read
    task pwr_round(input int b, input int how);
        logic [7:0] m;
        int         k;
        m = 8'h01 << b;
        @(posedge clk_sys_i);
        pmon <= m;
        cyc(3);
        pmon <= 8'h00;
        cyc(3);
        #1;
        chk("hold", 8'h01, {7'h00, hold});
        rdchk(`RCSB_ADDR_SUMMARY, 8'h08);
        rdchk(`RCSB_ADDR_POWER, m);
        if (how == 3) begin
            rdchk(`RCSB_ADDR_POWER, m);
            rdchk(`RCSB_ADDR_POWER, 8'h00);
        end
        k = 0;
        while (hold !== 1'b0 && k < 100) begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end
        if (k == 100) begin
            $display("[ERR] hold expected 0 seen %b", hold);
            miscompares++;
            stop_test();
        end
        cyc(2);
        #1;
        if (how < 3) begin
            chk("error code", {7'h00, how < 2}, {7'h00, errc});
        end
        if (how == 0) begin
            rdchk(`RCSB_ADDR_POWER, m);
        end
        if (how == 1) begin
            tx_pulse();
            chk("error code", 8'h00, {7'h00, errc});
        end
        rdchk(`RCSB_ADDR_POWER, 8'h00);
        tx_pulse();
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        cyc(6);
        resetn_i <= 1'b1;
        rdchk(`RCSB_ADDR_SUMMARY, 8'h03);
        rdchk(`RCSB_ADDR_SUMMARY, 8'h01);
        rdchk(`RCSB_ADDR_COUNT, 8'h00);
        cyc(START + 5);
        rdchk(`RCSB_ADDR_SUMMARY, 8'h00);
        cfg <= 8'h50;
        cyc(2);
        rdchk(`RCSB_ADDR_SUMMARY, 8'h01);
        cyc(START + 5);
        rdchk(`RCSB_ADDR_SUMMARY, 8'h00);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_i);
            dsp <= 5'h01 << i;
            rdchk(`RCSB_ADDR_SUMMARY, 8'h80);
        end
        dsp <= 5'h00;
        osc <= 1'b1;
        ftest <= 1'b1;
        rdchk(`RCSB_ADDR_SUMMARY, 8'h24);
        osc <= 1'b0;
        ftest <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_i);
            mev <= 4'h1 << i;
            @(posedge clk_sys_i);
            mev <= 4'h0;
            rdchk(`RCSB_ADDR_SUMMARY, 8'h10);
            mrd <= 1'b1;
            @(posedge clk_sys_i);
            mrd <= 1'b0;
            rdchk(`RCSB_ADDR_SUMMARY, 8'h00);
        end
        mwa <= 1'b1;
        rdchk(`RCSB_ADDR_SUMMARY, 8'h10);
        mwa <= 1'b0;
        rdchk(`RCSB_ADDR_SUMMARY, 8'h00);
        for (int p = 0; p < 8; p++) begin
            for (int g = 0; g < 2; g++) begin
                @(posedge clk_sys_i);
                psel <= p[2:0];
                diag <= g[0];
                master_u.access(1'b0, `RCSB_ADDR_COUNT, d, rf);
                chk("refused", {7'h00, !(p == 0 || p == 3 ||
                    ((p == 1 || p == 5) && g == 1))}, {7'h00, rf});
                if (rf === 1'b1) begin
                    chk("refused data", 8'h00, d);
                end
            end
        end
        psel <= `RCSB_PSEL_DSI3_A;
        master_u.access(1'b0, 8'h03, d, rf);
        chk("unmapped", 8'h01, {7'h00, rf});
        master_u.access(1'b1, `RCSB_ADDR_SUMMARY, d, rf);
        chk("write", 8'h01, {7'h00, rf});
        rdchk(`RCSB_ADDR_SUMMARY, 8'h00);
        master_u.access(1'b0, `RCSB_ADDR_COUNT, c1, rf);
        cyc(2498);
        rdchk(`RCSB_ADDR_COUNT, c1 + 8'h01);
        pwr_round(7, 0);
        pwr_round(6, 1);
        pwr_round(5, 3);
        psel <= `RCSB_PSEL_DSI3_B;
        pwr_round(3, 0);
        hold_dis <= 1'b1;
        pwr_round(0, 2);
        hold_dis <= 1'b0;
        diag <= 1'b1;
        psel <= `RCSB_PSEL_PSI5_A;
        pwr_round(2, 2);
        psel <= `RCSB_PSEL_PSI5_B;
        pwr_round(1, 2);
        stop_test();
    end
endmodule
`default_nettype wire
